// >>> nvsram_map.vh
`ifndef NVSRAM_MAP_VH
`define NVSRAM_MAP_VH
// ****************************************************************
// Timing in nanoseconds and derived cycle counts at 50 MHz
// ****************************************************************
`define CLK_PERIOD_NS       20
`define INIT_HOLD_NS        25
`define INIT_HOLD_CYC       ((`INIT_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_NS            5
`define SETUP_CYC           1
`define READ_ACCESS_NS      45
`define READ_ACCESS_CYC     ((`READ_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_PULSE_NS      35
`define WRITE_PULSE_CYC     ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STORE_TIME_NS       10000000
`define STORE_TIME_CYC      (`STORE_TIME_NS / `CLK_PERIOD_NS)
`define RECALL_TIME_NS      20000
`define RECALL_TIME_CYC     (`RECALL_TIME_NS / `CLK_PERIOD_NS)
// ****************************************************************
// Field widths and command codes
// ****************************************************************
`define ADDR_W              13
`define DATA_W              8
`define CNT_W               20
`define CMD_READ            2'h0
`define CMD_WRITE           2'h1
`define CMD_STORE           2'h2
`define CMD_RECALL          2'h3
`endif

// >>> wait_timer.v
`timescale 1ns/1ps
`include "nvsram_map.vh"
// ****************************************************************
// Down counter; o_done is a one-cycle pulse when the load expires
// ****************************************************************
module wait_timer (
  input  wire                i_ref_clk,
  input  wire                i_rstn,
  input  wire                i_load,    // Start a new wait
  input  wire [`CNT_W-1:0]   i_count,   // Cycles to wait, at least 1
  output reg                 o_done     // Pulse at the end of the wait
);
  reg [`CNT_W-1:0] remain;              // Cycles left
  reg              active;              // Wait in progress

  // Count down, reload wins over an ongoing count
  always @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      remain <= {`CNT_W{1'b0}};
      active <= 1'b0;
      o_done <= 1'b0;
    end else if (i_load) begin
      remain <= i_count - 20'h00001;
      active <= 1'b1;
      o_done <= 1'b0;
    end else if (active) begin
      if (remain == {`CNT_W{1'b0}}) begin
        active <= 1'b0;
        o_done <= 1'b1;
      end else begin
        remain <= remain - 20'h00001;
        o_done <= 1'b0;
      end
    end else begin
      o_done <= 1'b0;
    end
  end
endmodule

// >>> nv_sram_host.v
`timescale 1ns/1ps
`include "nvsram_map.vh"
module nv_sram_host #(
  parameter STORE_CYC  = `STORE_TIME_CYC,   // Store wait, shorten in simulation
  parameter RECALL_CYC = `RECALL_TIME_CYC   // Recall wait, shorten in simulation
) (
  input  wire                i_ref_clk,
  input  wire                i_rstn,
  input  wire                i_req_valid,    // Command request
  input  wire [1:0]          i_req_cmd,      // Read, write, store or recall
  input  wire [`ADDR_W-1:0]  i_req_addr,     // Byte address
  input  wire [`DATA_W-1:0]  i_req_wdata,    // Write data
  output wire                o_req_ready,    // Request accepted this cycle
  output reg                 o_rsp_valid,    // Command finished, one cycle
  output reg  [`DATA_W-1:0]  o_rsp_rdata,    // Read data
  output reg                 o_power_ok,     // Power-up recall wait over
  output reg  [`ADDR_W-1:0]  o_address_lines,
  input  wire [`DATA_W-1:0]  i_data_lines,
  output reg  [`DATA_W-1:0]  o_data_lines,
  output reg                 o_data_lines_oe,
  output reg                 o_chip_select_n,
  output reg                 o_write_strobe_n,
  output reg                 o_output_gate_n,
  output reg                 o_nonvolatile_select_n
);
  // ****************************************************************
  // States
  // ****************************************************************
  localparam [6:0] ST_BOOT  = 7'h01;  // Power-up recall wait
  localparam [6:0] ST_IDLE  = 7'h02;  // Deselected, waiting for work
  localparam [6:0] ST_SETUP = 7'h04;  // Controls set, select about to fall
  localparam [6:0] ST_ACT   = 7'h08;  // Strobe phase for a fixed time
  localparam [6:0] ST_REL   = 7'h10;  // Select release ending the strobe phase
  localparam [6:0] ST_NVWT  = 7'h20;  // Self-timed nonvolatile wait
  localparam [6:0] ST_DONE  = 7'h40;  // Report completion

  reg [6:0]          state;           // Current state
  reg [1:0]          cmd;             // Latched command
  reg [`DATA_W-1:0]  rd_sync1;        // Data pin synchroniser, first stage
  reg [`DATA_W-1:0]  rd_sync2;        // Data pin synchroniser, second stage
  reg                tmr_load;        // Timer start
  reg [`CNT_W-1:0]   tmr_count;       // Timer load value
  wire               tmr_done;        // Timer expiry

  // ****************************************************************
  // Timer loads
  // ****************************************************************
  // Whole integers here, cut to the counter width where they are loaded
  localparam integer READ_CYC  = `READ_ACCESS_CYC;  // Read strobe phase
  localparam integer WRITE_CYC = `WRITE_PULSE_CYC;  // Write strobe phase
  localparam integer HOLD_CYC  = `INIT_HOLD_CYC;    // Store or recall initiation hold

  assign o_req_ready = (state == ST_IDLE) && o_power_ok;

  wait_timer u_timer (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_load    (tmr_load),
    .i_count   (tmr_count),
    .o_done    (tmr_done)
  );

  // ****************************************************************
  // Data pin synchroniser
  // ****************************************************************
  // Two stages; only the second is sampled into the response
  always @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      rd_sync1 <= 8'h00;
      rd_sync2 <= 8'h00;
    end else begin
      rd_sync1 <= i_data_lines;
      rd_sync2 <= rd_sync1;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Each command drives a full cycle from deselect back to deselect,
  // so every start is a fresh select edge and never a lingering level
  always @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      state                  <= ST_BOOT;
      cmd                    <= `CMD_READ;
      tmr_load               <= 1'b1;
      tmr_count              <= RECALL_CYC[`CNT_W-1:0];
      o_rsp_valid            <= 1'b0;
      o_rsp_rdata            <= 8'h00;
      o_power_ok             <= 1'b0;
      o_address_lines        <= 13'h0000;
      o_data_lines           <= 8'h00;
      o_data_lines_oe        <= 1'b0;
      o_chip_select_n        <= 1'b1;
      o_write_strobe_n       <= 1'b1;
      o_output_gate_n        <= 1'b1;
      o_nonvolatile_select_n <= 1'b1;
    end else begin
      tmr_load    <= 1'b0;
      o_rsp_valid <= 1'b0;
      case (state)
        ST_BOOT: begin
          // no access before power-up recall ends
          if (tmr_done) begin
            o_power_ok <= 1'b1;
            state      <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (i_req_valid && o_power_ok) begin
            cmd             <= i_req_cmd;
            o_address_lines <= i_req_addr;
            o_data_lines    <= i_req_wdata;
            o_nonvolatile_select_n <= !(i_req_cmd == `CMD_STORE ||
                                        i_req_cmd == `CMD_RECALL);
            // gate high for write and store
            o_output_gate_n <= (i_req_cmd == `CMD_WRITE ||
                                i_req_cmd == `CMD_STORE);
            // strobe low before select on writes
            o_write_strobe_n <= !(i_req_cmd == `CMD_WRITE);
            state <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // select falls fresh for each cycle
          o_chip_select_n <= 1'b0;
          o_data_lines_oe <= (cmd == `CMD_WRITE);
          // store strobe falls last, after select
          // strobe low with gate high is a store
          if (cmd == `CMD_STORE) begin
            o_write_strobe_n <= 1'b1;
          end
          tmr_load  <= 1'b1;
          tmr_count <= (cmd == `CMD_READ)  ? READ_CYC[`CNT_W-1:0] :
                       (cmd == `CMD_WRITE) ? WRITE_CYC[`CNT_W-1:0] : HOLD_CYC[`CNT_W-1:0];
          state     <= ST_ACT;
        end
        ST_ACT: begin
          if (cmd == `CMD_STORE && o_write_strobe_n) begin
            // strobe last completes the store condition
            o_write_strobe_n <= 1'b0;
            tmr_load         <= 1'b1;
            tmr_count        <= HOLD_CYC[`CNT_W-1:0];
          end else if (tmr_done) begin
            state <= ST_REL;
          end
        end
        ST_REL: begin
          // release after the read access, write pulse or 25 ns hold time
          // recall ended by select, not strobe
          o_chip_select_n  <= 1'b1;
          o_data_lines_oe  <= 1'b0;
          if (cmd == `CMD_READ) begin
            // read data sampled after access time
            // two extra cycles cover synchroniser latency
            o_rsp_rdata <= rd_sync2;
          end
          if (cmd == `CMD_STORE || cmd == `CMD_RECALL) begin
            tmr_load  <= 1'b1;
            tmr_count <= (cmd == `CMD_STORE) ? STORE_CYC[`CNT_W-1:0] :
                                               RECALL_CYC[`CNT_W-1:0];
            state     <= ST_NVWT;
          end else begin
            state <= ST_DONE;
          end
        end
        ST_NVWT: begin
          o_write_strobe_n       <= 1'b1;
          o_nonvolatile_select_n <= 1'b1;
          o_output_gate_n        <= 1'b1;
          // pins idle until the wait expires
          if (tmr_done) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          o_write_strobe_n       <= 1'b1;
          o_nonvolatile_select_n <= 1'b1;
          o_output_gate_n        <= 1'b1;
          o_rsp_valid            <= 1'b1;
          state                  <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// >>> nv_sram_host_sva.sv
`timescale 1ns/1ps
`include "nvsram_map.vh"
// ****************************************************************
// Pin order checks on the host side
// ****************************************************************
module nv_sram_host_sva #(
  parameter STORE_CYC  = 20,  // Shortened store wait
  parameter RECALL_CYC = 10   // Shortened recall wait
) (
  input wire               i_ref_clk,
  input wire               i_rstn,
  input wire               o_req_ready,
  input wire               o_power_ok,
  input wire [`ADDR_W-1:0] o_address_lines,
  input wire               o_data_lines_oe,
  input wire               o_chip_select_n,
  input wire               o_write_strobe_n,
  input wire               o_output_gate_n,
  input wire               o_nonvolatile_select_n
);
  // Pin states as the device decodes them
  wire wr_c = !o_chip_select_n && !o_write_strobe_n && o_nonvolatile_select_n;
  wire st_c = !o_chip_select_n && !o_write_strobe_n && o_output_gate_n && !o_nonvolatile_select_n;
  wire rc_c = !o_chip_select_n && o_write_strobe_n && !o_output_gate_n && !o_nonvolatile_select_n;
  int unsigned boot_cnt;  // Cycles since reset release, saturating
  // Count the boot span so the recall wait can be checked without a long repetition
  always @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      boot_cnt <= 0;
    end else if (boot_cnt < 100000) begin
      boot_cnt <= boot_cnt + 1;
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  // 25 ns of initiation needs two whole cycles at 50 MHz
  sequence s_store_held;
    st_c [*2];
  endsequence
  sequence s_recall_held;
    rc_c [*2];
  endsequence
  a_write_gate_high:
    assert property (wr_c |-> o_output_gate_n) else $error("gate low in write");
  a_write_addr_stable:
    assert property (wr_c |-> $stable(o_address_lines)) else $error("address moved in write");
  a_store_order:
    assert property ($rose(st_c) |-> $past(!o_nonvolatile_select_n && o_output_gate_n))
      else $error("store entered in wrong order");
  a_store_held:
    assert property ($rose(st_c) |-> s_store_held) else $error("store start too short");
  a_recall_held:
    assert property ($rose(rc_c) |-> s_recall_held) else $error("recall start too short");
  a_recall_no_strobe:
    assert property (rc_c |=> o_write_strobe_n) else $error("recall ended by strobe");
  a_boot_quiet:
    assert property (!o_power_ok |-> o_write_strobe_n && o_chip_select_n)
      else $error("access during boot recall");
  a_ready_deselect:
    assert property (o_req_ready |-> o_chip_select_n && o_write_strobe_n &&
                     o_nonvolatile_select_n) else $error("ready while a cycle is open");
  a_boot_wait:
    assert property ($rose(o_power_ok) |-> boot_cnt >= RECALL_CYC)
      else $error("boot recall wait too short");
  a_gate_no_drive:
    assert property (!o_output_gate_n |-> !o_data_lines_oe) else $error("bus contention");
endmodule
bind nv_sram_host nv_sram_host_sva #(.STORE_CYC(STORE_CYC), .RECALL_CYC(RECALL_CYC)) i_chk (
  .i_ref_clk, .i_rstn, .o_req_ready, .o_power_ok, .o_address_lines, .o_data_lines_oe,
  .o_chip_select_n, .o_write_strobe_n, .o_output_gate_n, .o_nonvolatile_select_n);

// >>> nv_sram_dev.sv
`timescale 1ns/1ps
// ****************************************************************
// Behavioural nonvolatile SRAM on the far side
// ****************************************************************
module nv_sram_dev #(
  parameter STORE_NS  = 200,  // Kept below the host's store wait
  parameter RECALL_NS = 100   // Kept below the host's recall wait
) (
  input  wire [12:0] i_address_lines,
  input  wire [7:0]  i_data_lines,
  input  wire        i_chip_select_n,
  input  wire        i_write_strobe_n,
  input  wire        i_output_gate_n,
  input  wire        i_nonvolatile_select_n,
  output wire [7:0]  o_data_lines,
  output wire        o_data_lines_oe
);
  localparam logic SUPPLY_OK = 1'b1;  // No sense pin at the host, so supply is always good
  logic [7:0]    sram [0:8191];
  logic [7:0]    nvm [0:8191];
  logic          busy = 1'b1;          // Power-up recall runs from time zero
  wire  [7:0] #1 data_d = i_data_lines; // Byte just before the write ends; hold may be zero
  wire wr = !busy && !i_chip_select_n && !i_write_strobe_n && i_nonvolatile_select_n;
  wire st = SUPPLY_OK && !i_chip_select_n && !i_write_strobe_n && i_output_gate_n &&
            !i_nonvolatile_select_n;
  wire rc = !i_chip_select_n && i_write_strobe_n && !i_output_gate_n && !i_nonvolatile_select_n;
  // drive only in a clean read
  assign o_data_lines_oe = !busy && !i_chip_select_n && !i_output_gate_n && i_write_strobe_n &&
                           i_nonvolatile_select_n;
  assign o_data_lines    = sram[i_address_lines];
  // capture on whichever edge ends the write
  always @(negedge wr) sram[i_address_lines] <= data_d;
  initial begin
    for (int k = 0; k < 8192; k++) nvm[k] = k[7:0] ^ 8'h5A;
    #(RECALL_NS) sram = nvm;
    busy = 1'b0;
  end
  // start on a pin change, deaf while busy
  always @(st or rc) begin
    if (!busy && (st || rc)) begin
      busy = 1'b1;
      if (st) #(STORE_NS) nvm = sram;
      else #(RECALL_NS) sram = nvm;
      busy = 1'b0;
    end
  end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
// ****************************************************************
// Testbench: command driver, response scoreboard
// ****************************************************************
module tb_top;
  logic        clk = 0, rstn = 0, valid = 0;
  logic [1:0]  cmd = 0;
  logic [12:0] addr = 0;
  logic [7:0]  wd = 0, last = 0;
  logic [7:0]  es [0:8191], en [0:8191]; // Expected SRAM and nonvolatile images
  logic [8:0]  expq [$], note;           // Bit 8 set when a read byte is due
  logic [12:0] ra [0:5];
  logic [7:0]  rb [0:5];
  integer      seed = 32'h4AB7;
  int          n_mismatch = 0, n_compared = 0;
  wire         ready, rv, pok, h_oe, cs_n, we_n, g_n, nv_n, d_oe;
  wire [12:0]  al;
  wire [7:0]   rdata, hd, dd, bus;
  // Undriven bus shows the inverse of the last byte, so a stale value never passes
  assign bus = h_oe ? hd : (d_oe ? dd : ~last);
  always @(posedge clk) if (h_oe || d_oe) last <= bus;
  initial forever #10 clk = ~clk;
  nv_sram_host #(.STORE_CYC(20), .RECALL_CYC(10)) i_nv_sram_host (.i_ref_clk(clk),
    .i_rstn(rstn), .i_req_valid(valid), .i_req_cmd(cmd), .i_req_addr(addr), .i_req_wdata(wd),
    .o_req_ready(ready), .o_rsp_valid(rv), .o_rsp_rdata(rdata), .o_power_ok(pok),
    .o_address_lines(al), .i_data_lines(bus), .o_data_lines(hd), .o_data_lines_oe(h_oe),
    .o_chip_select_n(cs_n), .o_write_strobe_n(we_n), .o_output_gate_n(g_n),
    .o_nonvolatile_select_n(nv_n));
  nv_sram_dev i_nv_sram_dev (.i_address_lines(al), .i_data_lines(bus), .i_chip_select_n(cs_n),
    .i_write_strobe_n(we_n), .i_output_gate_n(g_n), .i_nonvolatile_select_n(nv_n),
    .o_data_lines(dd), .o_data_lines_oe(d_oe));
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  // One command; the note is queued before the handshake so the scoreboard never lags
  task automatic op(input logic [1:0] c, input logic [12:0] a, input logic [7:0] d);
    @(negedge clk);
    valid = 1;
    cmd = c;
    addr = a;
    wd = d;
    if (c == 2'h1) es[a] = d;
    if (c == 2'h2) en = es;
    if (c == 2'h3) es = en;
    expq.push_back({c == 2'h0, es[a]});
    while (ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    valid = 0;
    while (rv !== 1'b1) @(negedge clk);
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Scoreboard: oldest note against each response pulse
  always @(negedge clk) begin
    if (rv === 1'b1) begin
      note = expq.pop_front();
      if (note[8]) chk("read data", note[7:0], rdata);
    end
  end
  initial begin
    #400000;
    n_mismatch++;
    wrap_up;
  end
  initial begin
    for (int k = 0; k < 8192; k++) es[k] = k[7:0] ^ 8'h5A;
    en = es;
    repeat (16) @(negedge clk);
    chk("ready in reset", 8'h00, {7'h00, ready});
    rstn = 1;
    while (pok !== 1'b1) @(negedge clk);
    op(2'h0, 13'h0000, 8'h00);
    op(2'h0, 13'h1FFF, 8'h00);
    $display("test boot recall done");
    for (int k = 0; k < 6; k++) begin
      ra[k] = 13'($random(seed));
      rb[k] = 8'($random(seed));
      op(2'h1, ra[k], rb[k]);
    end
    op(2'h1, 13'h1FFF, 8'hC3);
    for (int k = 0; k < 6; k++) op(2'h0, ra[k], 8'h00);
    op(2'h0, 13'h1FFF, 8'h00);
    $display("test write read done");
    op(2'h2, 13'h0000, 8'h00);
    for (int k = 0; k < 6; k++) op(2'h1, ra[k], ~rb[k]);
    for (int k = 0; k < 6; k++) op(2'h0, ra[k], 8'h00);
    $display("test store overwrite done");
    op(2'h3, 13'h0000, 8'h00);
    for (int k = 0; k < 6; k++) op(2'h0, ra[k], 8'h00);
    op(2'h1, 13'h1FFF, 8'h3C);
    op(2'h2, 13'h0000, 8'h00);
    op(2'h2, 13'h0000, 8'h00);
    op(2'h3, 13'h0000, 8'h00);
    op(2'h0, 13'h1FFF, 8'h00);
    // Let the scoreboard take the last note before the queue is counted
    @(negedge clk);
    chk("pending notes", 8'h00, 8'(expq.size()));
    $display("test repeat store recall done");
    wrap_up;
  end
endmodule
